// ===== design/drcpr_pkg.sv
// Package for the DRC parameter register bank: offsets, field layout, reset values
package drcpr_pkg;
	// ==========================================================
	// Register offsets (7-bit control-port register address)
	localparam logic [6:0] DRCPR_ADDR_CTRL1 = 7'h1D;
	localparam logic [6:0] DRCPR_ADDR_GAIN_LIMITS = 7'h1E;
	localparam logic [6:0] DRCPR_ADDR_ATTACK_DECAY = 7'h1F;
	localparam logic [6:0] DRCPR_ADDR_KNEE_INPUTS = 7'h20;
	localparam logic [6:0] DRCPR_ADDR_KNEE_OUT_SLOPE = 7'h21;
	localparam int DRCPR_ADDR_W = 7;
	localparam int DRCPR_DATA_W = 16;

	// ==========================================================
	// Field positions
	localparam int DRCPR_NG_ENA_BIT = 8;
	localparam int DRCPR_FLOOR_LSB = 2;
	localparam int DRCPR_FLOOR_MSB = 4;
	localparam int DRCPR_CEIL_LSB = 0;
	localparam int DRCPR_CEIL_MSB = 1;
	localparam int DRCPR_ATK_LSB = 4;
	localparam int DRCPR_ATK_MSB = 7;
	localparam int DRCPR_DCY_LSB = 0;
	localparam int DRCPR_DCY_MSB = 3;
	localparam int DRCPR_GKI_LSB = 8;
	localparam int DRCPR_GKI_MSB = 12;
	localparam int DRCPR_CKI_LSB = 2;
	localparam int DRCPR_CKI_MSB = 7;
	localparam int DRCPR_GKO_EN_BIT = 13;
	localparam int DRCPR_GKO_LSB = 8;
	localparam int DRCPR_GKO_MSB = 12;
	localparam int DRCPR_CKO_LSB = 3;
	localparam int DRCPR_CKO_MSB = 7;
	localparam int DRCPR_SLOPE_LSB = 0;
	localparam int DRCPR_SLOPE_MSB = 2;

	// ==========================================================
	// Reset values of the fields
	localparam logic DRCPR_RST_NG_ENA = 1'h0;
	localparam logic [2:0] DRCPR_RST_FLOOR = 3'h1;
	localparam logic [1:0] DRCPR_RST_CEIL = 2'h1;
	localparam logic [3:0] DRCPR_RST_ATK = 4'h4;
	localparam logic [3:0] DRCPR_RST_DCY = 4'h2;
	localparam logic [4:0] DRCPR_RST_GKI = 5'h00;
	localparam logic [5:0] DRCPR_RST_CKI = 6'h00;
	localparam logic DRCPR_RST_GKO_EN = 1'h0;
	localparam logic [4:0] DRCPR_RST_GKO = 5'h00;
	localparam logic [4:0] DRCPR_RST_CKO = 5'h00;
	localparam logic [2:0] DRCPR_RST_SLOPE = 3'h3;

	// ==========================================================
	// Highest legal codes and lowest attack code; anything above a maximum or below the minimum is reserved
	localparam logic [2:0] DRCPR_MAX_FLOOR = 3'h4;
	localparam logic [3:0] DRCPR_MIN_ATK = 4'h1;
	localparam logic [3:0] DRCPR_MAX_ATK = 4'hB;
	localparam logic [3:0] DRCPR_MAX_DCY = 4'h8;
	localparam logic [5:0] DRCPR_MAX_CKI = 6'h3C;
	localparam logic [4:0] DRCPR_MAX_CKO = 5'h1E;
	localparam logic [2:0] DRCPR_MAX_SLOPE = 3'h5;
endpackage

// ===== design/drcpr_field.sv
// One register field with reset value and write strobe
`timescale 1ns/1ps
module drcpr_field #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Write side
	input wire logic i_we,
	input wire logic [W-1:0] i_d,
	// Held value
	output logic [W-1:0] o_q
);
	// ==========================================================
	// Storage
	// Holds the last written value so reads return it unchanged
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_q <= RST;
		else if (i_we)
			o_q <= i_d;
	end
endmodule

// ===== design/drc_parameter_registers.sv
// DRC parameter register bank: gain limits, attack/decay, knees and upper slope
`timescale 1ns/1ps
module drc_parameter_registers
	import drcpr_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Control-port register access
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DRCPR_ADDR_W-1:0] i_addr,
	input wire logic [DRCPR_DATA_W-1:0] i_wdata,
	output logic [DRCPR_DATA_W-1:0] o_rdata,
	output logic o_hit,
	// Parameters to the DRC datapath
	output logic o_noise_gate_enable,
	output logic [2:0] o_attenuation_floor_code,
	output logic [1:0] o_boost_ceiling_code,
	output logic [3:0] o_attack_rate_code,
	output logic [3:0] o_decay_rate_code,
	output logic [4:0] o_gate_knee_input_level,
	output logic o_gate_knee_input_valid,
	output logic [5:0] o_comp_knee_input_level,
	output logic o_gate_knee_output_override_en,
	output logic [4:0] o_gate_knee_output_level,
	output logic o_gate_knee_output_valid,
	output logic [4:0] o_comp_knee_output_level,
	output logic [2:0] o_upper_region_slope,
	// Reserved code currently held in some field
	output logic o_reserved_code
);
	// ==========================================================
	// Reset synchroniser
	// Entry is immediate, exit waits two edges so no field leaves reset on a
	// metastable sample; nothing but rst_sync reads the first flop
	logic rst_meta;
	logic rst_sync;
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// ==========================================================
	// Address decode
	// One select per mapped address; the offsets differ, so at most one is high
	wire sel_c1 = (i_addr == DRCPR_ADDR_CTRL1);
	wire sel_gl = (i_addr == DRCPR_ADDR_GAIN_LIMITS);
	wire sel_ad = (i_addr == DRCPR_ADDR_ATTACK_DECAY);
	wire sel_ki = (i_addr == DRCPR_ADDR_KNEE_INPUTS);
	wire sel_ko = (i_addr == DRCPR_ADDR_KNEE_OUT_SLOPE);

	// Write enables; a write to any other address reaches no field
	wire we_c1 = i_wr && sel_c1;
	wire we_gl = i_wr && sel_gl;
	wire we_ad = i_wr && sel_ad;
	wire we_ki = i_wr && sel_ki;
	wire we_ko = i_wr && sel_ko;

	// Hit flag for the bus side, decoded from the address alone
	assign o_hit = sel_c1 | sel_gl | sel_ad | sel_ki | sel_ko;

	// ==========================================================
	// Field storage
	// Each field is its own flop group, so a write touches only its register
	logic ng_ena;
	logic [2:0] floor_q;
	logic [1:0] ceil_q;
	logic [3:0] atk_q;
	logic [3:0] dcy_q;
	logic [4:0] gki_q;
	logic [5:0] cki_q;
	logic gko_en_q;
	logic [4:0] gko_q;
	logic [4:0] cko_q;
	logic [2:0] slope_q;

	// Noise gate enable in the first control register
	drcpr_field #(.W(1), .RST(DRCPR_RST_NG_ENA)) u_ng_ena (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_c1),
		.i_d(i_wdata[DRCPR_NG_ENA_BIT]), .o_q(ng_ena));
	// Gain limits
	drcpr_field #(.W(3), .RST(DRCPR_RST_FLOOR)) u_floor (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_gl),
		.i_d(i_wdata[DRCPR_FLOOR_MSB:DRCPR_FLOOR_LSB]), .o_q(floor_q));
	drcpr_field #(.W(2), .RST(DRCPR_RST_CEIL)) u_ceil (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_gl),
		.i_d(i_wdata[DRCPR_CEIL_MSB:DRCPR_CEIL_LSB]), .o_q(ceil_q));
	// Attack and decay rates
	drcpr_field #(.W(4), .RST(DRCPR_RST_ATK)) u_atk (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ad),
		.i_d(i_wdata[DRCPR_ATK_MSB:DRCPR_ATK_LSB]), .o_q(atk_q));
	drcpr_field #(.W(4), .RST(DRCPR_RST_DCY)) u_dcy (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ad),
		.i_d(i_wdata[DRCPR_DCY_MSB:DRCPR_DCY_LSB]), .o_q(dcy_q));
	// Knee input levels
	drcpr_field #(.W(5), .RST(DRCPR_RST_GKI)) u_gki (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ki),
		.i_d(i_wdata[DRCPR_GKI_MSB:DRCPR_GKI_LSB]), .o_q(gki_q));
	drcpr_field #(.W(6), .RST(DRCPR_RST_CKI)) u_cki (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ki),
		.i_d(i_wdata[DRCPR_CKI_MSB:DRCPR_CKI_LSB]), .o_q(cki_q));
	// Knee outputs, override enable and upper slope
	drcpr_field #(.W(1), .RST(DRCPR_RST_GKO_EN)) u_gko_en (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ko),
		.i_d(i_wdata[DRCPR_GKO_EN_BIT]), .o_q(gko_en_q));
	drcpr_field #(.W(5), .RST(DRCPR_RST_GKO)) u_gko (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ko),
		.i_d(i_wdata[DRCPR_GKO_MSB:DRCPR_GKO_LSB]), .o_q(gko_q));
	drcpr_field #(.W(5), .RST(DRCPR_RST_CKO)) u_cko (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ko),
		.i_d(i_wdata[DRCPR_CKO_MSB:DRCPR_CKO_LSB]), .o_q(cko_q));
	drcpr_field #(.W(3), .RST(DRCPR_RST_SLOPE)) u_slope (
		.i_clk(i_clk), .i_rstn(rst_sync), .i_we(we_ko),
		.i_d(i_wdata[DRCPR_SLOPE_MSB:DRCPR_SLOPE_LSB]), .o_q(slope_q));

	// ==========================================================
	// Parameter outputs straight from the field flops
	// Codes go out as stored: a reserved code is flagged below, never altered
	assign o_noise_gate_enable = ng_ena;
	assign o_attenuation_floor_code = floor_q;
	assign o_boost_ceiling_code = ceil_q;
	assign o_attack_rate_code = atk_q;
	assign o_decay_rate_code = dcy_q;
	assign o_gate_knee_input_level = gki_q;
	assign o_comp_knee_input_level = cki_q;
	assign o_gate_knee_output_override_en = gko_en_q;
	assign o_gate_knee_output_level = gko_q;
	assign o_comp_knee_output_level = cko_q;
	assign o_upper_region_slope = slope_q;

	// Qualifiers tell the datapath when a level is to be used at all
	// The levels stay visible so software can stage them before enabling
	assign o_gate_knee_input_valid = ng_ena;
	assign o_gate_knee_output_valid = gko_en_q;

	// ==========================================================
	// Reserved-code detection; stored anyway so read-back stays honest
	// Gain and rate fields; the boost ceiling uses all four codes
	wire rsv_floor = (floor_q > DRCPR_MAX_FLOOR);
	wire rsv_atk = (atk_q < DRCPR_MIN_ATK) || (atk_q > DRCPR_MAX_ATK);
	wire rsv_dcy = (dcy_q > DRCPR_MAX_DCY);

	// Knee levels and slope; both gate levels use every code
	wire rsv_cki = (cki_q > DRCPR_MAX_CKI);
	wire rsv_cko = (cko_q > DRCPR_MAX_CKO);
	wire rsv_slope = (slope_q > DRCPR_MAX_SLOPE);

	// One flag for all fields; software reads the registers to find which one
	assign o_reserved_code = rsv_floor | rsv_atk | rsv_dcy | rsv_cki | rsv_cko | rsv_slope;

	// ==========================================================
	// Read-back images; unlisted bits read as zero
	logic [DRCPR_DATA_W-1:0] img_c1;
	logic [DRCPR_DATA_W-1:0] img_gl;
	logic [DRCPR_DATA_W-1:0] img_ad;
	logic [DRCPR_DATA_W-1:0] img_ki;
	logic [DRCPR_DATA_W-1:0] img_ko;
	always_comb
	begin
		// Clear first so bits that hold no field read as zero
		img_c1 = '0;
		img_gl = '0;
		img_ad = '0;
		img_ki = '0;
		img_ko = '0;
		// Then each field drops into its own bit positions
		img_c1[DRCPR_NG_ENA_BIT] = ng_ena;
		img_gl[DRCPR_FLOOR_MSB:DRCPR_FLOOR_LSB] = floor_q;
		img_gl[DRCPR_CEIL_MSB:DRCPR_CEIL_LSB] = ceil_q;
		img_ad[DRCPR_ATK_MSB:DRCPR_ATK_LSB] = atk_q;
		img_ad[DRCPR_DCY_MSB:DRCPR_DCY_LSB] = dcy_q;
		img_ki[DRCPR_GKI_MSB:DRCPR_GKI_LSB] = gki_q;
		img_ki[DRCPR_CKI_MSB:DRCPR_CKI_LSB] = cki_q;
		img_ko[DRCPR_GKO_EN_BIT] = gko_en_q;
		img_ko[DRCPR_GKO_MSB:DRCPR_GKO_LSB] = gko_q;
		img_ko[DRCPR_CKO_MSB:DRCPR_CKO_LSB] = cko_q;
		img_ko[DRCPR_SLOPE_MSB:DRCPR_SLOPE_LSB] = slope_q;
	end

	// Read mux; unmapped addresses read zero
	// A priority chain is safe here because the selects never overlap
	wire [DRCPR_DATA_W-1:0] rd_mux =
		sel_c1 ? img_c1 :
		sel_gl ? img_gl :
		sel_ad ? img_ad :
		sel_ki ? img_ki :
		sel_ko ? img_ko : 16'h0000;

	// Registered read data, loaded on a read strobe and held until the next
	// A write in the same cycle is not seen: the mux reads the flops before they load
	always_ff @(posedge i_clk or negedge rst_sync)
	begin
		if (!rst_sync)
			o_rdata <= 16'h0000;
		else if (i_rd)
			o_rdata <= rd_mux;
	end
endmodule

// ===== sim/drcpr_assertions.sv
// Port checker for the DRC parameter register bank
`timescale 1ns/1ps
module drcpr_checker
	import drcpr_pkg::*;
(
	// Clock, reset and access
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [6:0] i_addr,
	input wire logic [15:0] i_wdata,
	// Watched outputs
	input wire logic [15:0] o_rdata,
	input wire logic [2:0] o_attenuation_floor_code,
	input wire logic [1:0] o_boost_ceiling_code,
	input wire logic o_gate_knee_input_valid,
	input wire logic o_gate_knee_output_override_en,
	input wire logic o_gate_knee_output_valid,
	input wire logic [2:0] o_upper_region_slope
);
	// ==========================================================
	// Properties
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Gain limit write, idle cycle, read back
	sequence s_wr_gap_rd;
		i_wr && i_addr == 7'h1E ##1 !i_wr ##1 i_rd && !i_wr && i_addr == 7'h1E;
	endsequence
	chk_floor_write: assert property (
		i_wr && i_addr == 7'h1E |=> o_attenuation_floor_code == $past(i_wdata[4:2]))
		else $error("floor not written");
	chk_ceil_write: assert property (
		i_wr && i_addr == 7'h1E |=> o_boost_ceiling_code == $past(i_wdata[1:0]))
		else $error("ceiling not written");
	chk_slope_write: assert property (
		i_wr && i_addr == 7'h21 |=> o_upper_region_slope == $past(i_wdata[2:0]))
		else $error("slope not written");
	chk_gate_in_valid: assert property (
		i_wr && i_addr == 7'h1D |=> o_gate_knee_input_valid == $past(i_wdata[8]))
		else $error("gate input qualifier wrong");
	chk_gate_out_valid: assert property (
		i_wr && i_addr == 7'h21 |=> {o_gate_knee_output_override_en,
		o_gate_knee_output_valid} == {2{$past(i_wdata[13])}})
		else $error("gate output qualifier wrong");
	chk_reset_vals: assert property (
		$rose(i_rstn) |-> o_attenuation_floor_code == DRCPR_RST_FLOOR
		&& o_boost_ceiling_code == DRCPR_RST_CEIL && o_upper_region_slope == DRCPR_RST_SLOPE)
		else $error("reset value wrong");
	chk_read_back: assert property (
		s_wr_gap_rd |=> o_rdata == ($past(i_wdata, 3) & 16'h001F))
		else $error("read back differs");
	chk_rdata_hold: assert property (
		!i_rd |=> $stable(o_rdata))
		else $error("read data moved");
endmodule
bind drc_parameter_registers drcpr_checker u_chk (.i_clk, .i_rstn, .i_wr, .i_rd, .i_addr,
	.i_wdata, .o_rdata, .o_attenuation_floor_code, .o_boost_ceiling_code,
	.o_gate_knee_input_valid, .o_gate_knee_output_override_en, .o_gate_knee_output_valid,
	.o_upper_region_slope);

// ===== sim/testbench.sv
// Self-checking testbench for the DRC parameter register bank
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Signals and device
	logic i_clk = 1'h0, i_rstn = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
	logic [6:0] i_addr = 7'h00;
	logic [15:0] i_wdata = 16'h0000, o_rdata;
	logic o_hit, o_noise_gate_enable, o_gate_knee_input_valid, o_reserved_code;
	logic o_gate_knee_output_override_en, o_gate_knee_output_valid;
	logic [2:0] o_attenuation_floor_code, o_upper_region_slope;
	logic [1:0] o_boost_ceiling_code;
	logic [3:0] o_attack_rate_code, o_decay_rate_code;
	logic [4:0] o_gate_knee_input_level, o_gate_knee_output_level, o_comp_knee_output_level;
	logic [5:0] o_comp_knee_input_level;
	int num_errors = 0, n_tests = 0;
	drc_parameter_registers DUT (.i_clk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
		.o_hit, .o_noise_gate_enable, .o_attenuation_floor_code, .o_boost_ceiling_code,
		.o_attack_rate_code, .o_decay_rate_code, .o_gate_knee_input_level,
		.o_gate_knee_input_valid, .o_comp_knee_input_level, .o_gate_knee_output_override_en,
		.o_gate_knee_output_level, .o_gate_knee_output_valid, .o_comp_knee_output_level,
		.o_upper_region_slope, .o_reserved_code);
	// 100 MHz clock
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	// ==========================================================
	// Helpers
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One-cycle strobes; the #1 lets the taking edge settle before sampling
	task acc(input logic w, input logic r, input logic [6:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'h0;
		i_rd <= 1'h0;
		#1;
	endtask
	task wrap_up;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		acc(0, 1, 7'h1E, 0);
		chk(o_rdata, 16'h0005);
		acc(0, 1, 7'h1F, 0);
		chk(o_rdata, 16'h0042);
		acc(0, 1, 7'h21, 0);
		chk(o_rdata, 16'h0003);
		chk({o_gate_knee_output_override_en, o_gate_knee_output_valid}, 2'h0);
	endtask
	// Junk in the unused upper bits must not reach any field
	task t_gain;
		for (int c = 0; c < 5; c++)
		begin
			acc(1, 0, 7'h1E, {11'h7FF, 3'(c), 2'(c)});
			chk({o_attenuation_floor_code, o_boost_ceiling_code}, {3'(c), 2'(c)});
			acc(0, 1, 7'h1E, 0);
			chk(o_rdata, {11'h0, 3'(c), 2'(c)});
		end
		for (int c = 1; c < 12; c++)
		begin
			acc(1, 0, 7'h1F, {8'hA5, 4'(c), 4'((c - 1) % 9)});
			chk({o_attack_rate_code, o_decay_rate_code}, {4'(c), 4'((c - 1) % 9)});
		end
	endtask
	// Write and read in one cycle returns the old value
	task t_knees;
		acc(1, 1, 7'h20, 16'hFFF2);
		chk(o_rdata, 16'h0000);
		acc(0, 1, 7'h20, 0);
		chk(o_rdata, 16'h1FF0);
		chk({o_gate_knee_input_level, o_comp_knee_input_level}, {5'h1F, 6'h3C});
		acc(1, 0, 7'h21, 16'hDEF5);
		chk({o_gate_knee_output_level, o_comp_knee_output_level}, 10'h3DE);
		chk({o_gate_knee_output_valid, o_upper_region_slope, o_reserved_code}, 5'h0A);
		acc(1, 1, 7'h21, 16'hFFFF);
		chk(o_rdata, 16'h1EF5);
		chk(o_hit, 1'h1);
		chk({o_gate_knee_output_valid, o_reserved_code}, 2'h3);
	endtask
	// A reserved floor, attack, decay or comp knee input code alone must raise the flag, a legal one must clear it
	task t_reserved;
		acc(1, 0, 7'h21, 16'h0005);
		chk(o_reserved_code, 1'h0);
		acc(1, 0, 7'h1E, 16'h0014);
		chk(o_reserved_code, 1'h1);
		acc(1, 0, 7'h1E, 16'h0010);
		acc(1, 0, 7'h1F, 16'h0008);
		chk(o_reserved_code, 1'h1);
		acc(1, 0, 7'h1F, 16'h00B9);
		chk(o_reserved_code, 1'h1);
		acc(1, 0, 7'h1F, 16'h00B8);
		acc(1, 0, 7'h20, 16'h00F4);
		chk(o_reserved_code, 1'h1);
		acc(1, 0, 7'h20, 16'h00F0);
		chk(o_reserved_code, 1'h0);
	endtask
	// Gate enable, unmapped access, then reset in mid-run
	task t_gate;
		acc(1, 0, 7'h1D, 16'h0100);
		chk({o_noise_gate_enable, o_gate_knee_input_valid}, 2'h3);
		acc(1, 1, 7'h22, 16'hFFFF);
		chk(o_rdata, 16'h0000);
		chk(o_hit, 1'h0);
		@(posedge i_clk);
		i_rstn <= 1'h0;
		@(posedge i_clk);
		#1;
		chk({o_attenuation_floor_code, o_upper_region_slope, o_reserved_code}, 7'h16);
		chk(o_gate_knee_input_valid, 1'h0);
	endtask
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'h1;
		repeat (3) @(posedge i_clk);
		t_reset;
		t_gain;
		t_knees;
		t_reserved;
		t_gate;
		@(posedge i_clk);
		i_rstn <= 1'h1;
		repeat (3) @(posedge i_clk);
		t_reset;
		wrap_up;
	end
	// Watchdog well beyond the hundred or so cycles the run needs
	initial
	begin
		#50000;
		num_errors++;
		wrap_up;
	end
endmodule
